// *** dgia_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// cpu side: AXI4-Lite slave that drives the device port
module dgia_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  dgia_if.host             bus,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  import dgia_pkg::*;

  typedef enum {DGIA_IDLE, DGIA_READ} dgia_state_t;
  dgia_state_t state;       // device read in flight or not
  logic        aw_got;      // write address held
  logic        w_got;       // write data held
  logic        ar_got;      // read address held
  logic [7:0]  aw_q;        // held write address
  logic [7:0]  ar_q;        // held read address
  logic [31:0] w_q;         // held write data
  logic [3:0]  s_q;         // held strobes
  logic [31:0] dev_addr;    // device offset register
  logic [31:0] dev_wdata;   // device write data register
  logic [31:0] dev_rdata;   // last device read result

  ////////////////////////////////////////////////////////////
  // decode of the held write and read
  wire do_wr   = aw_got & w_got & ~bvalid;
  wire do_rd   = ar_got & ~rvalid;
  wire aw_hs   = awvalid & awready;
  wire w_hs    = wvalid & wready;
  wire ar_hs   = arvalid & arready;
  wire busy    = state != DGIA_IDLE;
  wire w_addr  = aw_q == H_ADDR_OFS;
  wire w_wdat  = aw_q == H_WDATA_OFS;
  wire w_ctrl  = aw_q == H_CTRL_OFS;
  wire w_msg   = aw_q == H_MSG_OFS;
  wire w_ok    = w_addr | w_wdat | w_ctrl | w_msg;
  wire [31:0] bmask = {{8{s_q[3]}}, {8{s_q[2]}},
                       {8{s_q[1]}}, {8{s_q[0]}}};
  wire [31:0] wmerge_a = (dev_addr & ~bmask) | (w_q & bmask);
  wire [31:0] wmerge_d = (dev_wdata & ~bmask) | (w_q & bmask);
  // a start is dropped while a device read is in flight
  wire start_wr = do_wr & w_ctrl & w_q[CTRL_START_WR] & ~busy;
  wire start_rd = do_wr & w_ctrl & w_q[CTRL_START_RD]
                & ~w_q[CTRL_START_WR] & ~busy;
  wire send_msg = do_wr & w_msg;
  wire [31:0] status = {30'h0, bus.cpu_irq, busy};
  wire r_ok = (ar_q == H_ADDR_OFS) | (ar_q == H_WDATA_OFS)
            | (ar_q == H_CTRL_OFS) | (ar_q == H_RDATA_OFS)
            | (ar_q == H_STATUS_OFS) | (ar_q == H_MSG_OFS);
  wire [31:0] rd_mux =
    (ar_q == H_ADDR_OFS)   ? dev_addr  :
    (ar_q == H_WDATA_OFS)  ? dev_wdata :
    (ar_q == H_RDATA_OFS)  ? dev_rdata :
    (ar_q == H_STATUS_OFS) ? status    : 32'h00000000;
  wire next_aw_got = (aw_got | aw_hs) & ~do_wr;
  wire next_w_got  = (w_got | w_hs) & ~do_wr;
  wire next_bvalid = do_wr | (bvalid & ~bready);
  wire next_ar_got = (ar_got | ar_hs) & ~do_rd;
  wire next_rvalid = do_rd | (rvalid & ~rready);

  ////////////////////////////////////////////////////////////
  // AXI handshakes; each ready only while its own channel holds nothing and its response is not pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      ar_got  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      arready <= 1'b0;
      bvalid  <= 1'b0;
      rvalid  <= 1'b0;
    end else begin
      aw_got  <= next_aw_got;
      w_got   <= next_w_got;
      ar_got  <= next_ar_got;
      awready <= ~next_aw_got & ~next_bvalid;
      wready  <= ~next_w_got & ~next_bvalid;
      arready <= ~next_ar_got & ~next_rvalid;
      bvalid  <= next_bvalid;
      rvalid  <= next_rvalid;
    end
  end

  // payload capture, cleared at reset like the handshake flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q  <= 8'h00;
      ar_q  <= 8'h00;
      w_q   <= 32'h00000000;
      s_q   <= 4'h0;
      bresp <= RESP_OKAY;
      rresp <= RESP_OKAY;
      rdata <= 32'h00000000;
    end else begin
      if (aw_hs)
        aw_q <= awaddr;
      if (ar_hs)
        ar_q <= araddr;
      if (w_hs) begin
        w_q <= wdata;
        s_q <= wstrb;
      end
      if (do_wr)
        bresp <= w_ok ? RESP_OKAY : RESP_SLVERR;
      if (do_rd) begin
        rdata <= rd_mux;
        rresp <= r_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // software registers and device port strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_addr      <= 32'h00000000;
      dev_wdata     <= 32'h00000000;
      dev_rdata     <= 32'h00000000;
      state         <= DGIA_IDLE;
      bus.reg_addr  <= 20'h00000;
      bus.reg_wdata <= 32'h00000000;
      bus.reg_wr    <= 1'b0;
      bus.reg_rd    <= 1'b0;
      bus.msg_valid <= 1'b0;
      bus.msg_addr  <= 20'h00000;
      bus.msg_data  <= 32'h00000000;
    end else begin
      bus.reg_wr    <= start_wr;
      bus.reg_rd    <= start_rd;
      bus.msg_valid <= send_msg;
      if (do_wr && w_addr)
        dev_addr <= wmerge_a;
      if (do_wr && w_wdat)
        dev_wdata <= wmerge_d;
      if (start_wr || start_rd) begin
        bus.reg_addr  <= dev_addr[19:0];
        bus.reg_wdata <= dev_wdata;
      end
      if (send_msg) begin
        bus.msg_addr <= CORE_MSG_ADDR;
        bus.msg_data <= w_q;
      end
      // wait for the device answer, however long it takes
      case (state)
        DGIA_IDLE: if (start_rd) state <= DGIA_READ;
        DGIA_READ: if (bus.reg_rvalid) begin
          dev_rdata <= bus.reg_rdata;
          state     <= DGIA_IDLE;
        end
        default: state <= DGIA_IDLE;
      endcase
    end
  end
endmodule // dgia_host
`default_nettype wire

// *** dgia_pkg.sv ***
`default_nettype none
package dgia_pkg;
  // display register offsets on the device port
  localparam logic [19:0] DISP_LIVE_OFS  = 20'h44000;
  localparam logic [19:0] DISP_MASK_OFS  = 20'h44004;
  localparam logic [19:0] DISP_IDENT_OFS = 20'h44008;
  localparam logic [19:0] DISP_EN_OFS    = 20'h4400C;
  // message write targets for graphics core sources
  localparam logic [19:0] CORE_MSG_ADDR  = 20'h50200;
  // reset values
  localparam logic [31:0] MASK_RESET  = 32'hFFFFFFFF;
  localparam logic [31:0] IDENT_RESET = 32'h00000000;
  localparam logic [31:0] EN_RESET    = 32'h00000000;
  // master gate position, only in the enable register
  localparam int          MASTER_BIT  = 31;
  localparam logic [31:0] MASTER_MASK = 32'h80000000;
  // implemented display source bits per variant
  localparam logic [31:0] DISP_IMPL_V1 = 32'h3FF7FFFF;
  localparam logic [31:0] DISP_IMPL_V2 = 32'h3DF7FFFF;
  // graphics core source maps per variant
  localparam logic [31:0] CORE_MAP_V1 = 32'h000002FD;
  localparam logic [31:0] CORE_MAP_V2 = 32'h274DD0DD;
  // first variant core bit positions
  localparam int CORE_SYNC  = 2;
  localparam int CORE_ERROR = 3;
  localparam int CORE_FENCE = 4;
  // host register offsets (AXI4-Lite byte addresses)
  localparam logic [7:0] H_ADDR_OFS   = 8'h00;
  localparam logic [7:0] H_WDATA_OFS  = 8'h04;
  localparam logic [7:0] H_CTRL_OFS   = 8'h08;
  localparam logic [7:0] H_RDATA_OFS  = 8'h0C;
  localparam logic [7:0] H_STATUS_OFS = 8'h10;
  localparam logic [7:0] H_MSG_OFS    = 8'h14;
  // host control and status fields
  localparam int CTRL_START_WR = 0;
  localparam int CTRL_START_RD = 1;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_IRQ      = 1;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// *** dgia_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface dgia_if;
  logic [19:0] reg_addr;    // register offset
  logic        reg_wr;      // write strobe, one cycle
  logic        reg_rd;      // read strobe, one cycle
  logic [31:0] reg_wdata;   // write data
  logic [31:0] reg_rdata;   // read data
  logic        reg_rvalid;  // read data valid, one cycle
  logic        msg_valid;   // interrupt message write
  logic [19:0] msg_addr;    // message target
  logic [31:0] msg_data;    // message bits written as 1
  logic        cpu_irq;     // interrupt to the cpu
  modport dev (input reg_addr, reg_wr, reg_rd, reg_wdata,
               msg_valid, msg_addr, msg_data,
               output reg_rdata, reg_rvalid, cpu_irq);
  modport host (output reg_addr, reg_wr, reg_rd, reg_wdata,
                msg_valid, msg_addr, msg_data,
                input reg_rdata, reg_rvalid, cpu_irq);
endinterface
`default_nettype wire

// *** dgia_sticky_bit.sv ***
`timescale 1ns/1ns
`default_nettype none
// one identity bit with room for one more pending occurrence
module dgia_sticky_bit (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic live,     // live status of the source
  input  wire logic masked,   // mask bit, 1 blocks latching
  input  wire logic clear,    // software wrote 1 here
  output logic      ident     // sticky identity bit
);
  logic prev_live;  // last live value, for edge finding
  logic pending;    // second occurrence held behind ident
  wire  rise = live & ~prev_live & ~masked;

  ////////////////////////////////////////////////////////////
  // latch, clear and queue; a rise beats a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_live <= 1'b0;
      ident     <= 1'b0;
      pending   <= 1'b0;
    end else begin
      prev_live <= live;
      if (clear && ident) begin
        // queued or fresh event re-asserts at once
        ident   <= pending | rise;
        pending <= pending & rise;
      end else if (rise && ident) begin
        pending <= 1'b1;
      end else if (rise) begin
        ident <= 1'b1;
      end
    end
  end
endmodule // dgia_sticky_bit
`default_nettype wire

// *** dgia_device.sv ***
`timescale 1ns/1ns
`default_nettype none
module dgia_device #(
  parameter int VARIANT = 1  // 1: wired core sources, 2: messages
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  dgia_if.dev              bus,
  input  wire logic [31:0] display_events,   // display sources
  input  wire logic [31:0] core_wires,       // first variant wires
  input  wire logic        core_error,       // error id level
  input  wire logic        flush_sync_done,  // parser flush, sync on
  input  wire logic        engines_flushed,  // all engines idle
  input  wire logic        fence_notify,     // fence wants interrupt
  input  wire logic        fence_store_done, // fence data stored
  input  wire logic        legacy_line_mode, // line interrupt in use
  input  wire logic        core_irq_result,  // enabled core result
  input  wire logic        power_irq_result, // enabled power result
  output logic      [31:0] core_sources      // core live sources
);
  import dgia_pkg::*;

  // elaboration check on the variant
  // other values leave the core map open
  if (VARIANT != 1 && VARIANT != 2) begin : g_bad
    $error("VARIANT must be 1 or 2");
  end

  ////////////////////////////////////////////////////////////
  // constants chosen by variant
  // reserved positions get no cell
  localparam logic [31:0] IMPL =
    (VARIANT == 1) ? DISP_IMPL_V1 : DISP_IMPL_V2;
  localparam logic [31:0] EN_IMPL = IMPL | MASTER_MASK;

  logic [31:0] mask;       // display mask register
  logic [31:0] enable;     // display enable register
  logic [31:0] ident;      // display identity bits
  logic        flush_wait; // flush seen, engines still busy
  logic        sync_tgl;   // toggling sync status bit
  logic        fence_wait; // fence seen, store not done
  logic        fence_out;  // fence notify released
  // the last four serve only variant 1

  ////////////////////////////////////////////////////////////
  // address decode
  // offsets match in full, no aliases
  wire hit_live  = bus.reg_addr == DISP_LIVE_OFS;
  wire hit_mask  = bus.reg_addr == DISP_MASK_OFS;
  wire hit_ident = bus.reg_addr == DISP_IDENT_OFS;
  wire hit_en    = bus.reg_addr == DISP_EN_OFS;
  wire wr_mask   = bus.reg_wr & hit_mask;
  wire wr_en     = bus.reg_wr & hit_en;
  wire wr_ident  = bus.reg_wr & hit_ident;

  // live status is the raw condition, never latched
  // pulses may be gone before a read
  wire [31:0] live = display_events & IMPL;

  // only the enabled identity bits count; master gates all
  // identity bit 31 is always zero
  wire disp_any = |(ident & enable & ~MASTER_MASK);
  wire master   = enable[MASTER_BIT];
  wire next_irq = master &
    (disp_any | core_irq_result | power_irq_result);

  // read mux; live is read-only, writes there are dropped
  // unmapped offsets read zero
  wire [31:0] rd_mux =
    hit_live  ? live   :
    hit_mask  ? mask   :
    hit_ident ? ident  :
    hit_en    ? enable : 32'h00000000;

  ////////////////////////////////////////////////////////////
  // one sticky cell per implemented bit; gaps read zero
  // more flops, but clears stay per bit
  for (genvar i = 0; i < 32; i++) begin : g_bit
    if (IMPL[i]) begin : g_on
      dgia_sticky_bit u_bit (
        .aclk    (aclk),
        .aresetn (aresetn),
        .live    (live[i]),
        .masked  (mask[i]),
        .clear   (wr_ident & bus.reg_wdata[i]),
        .ident   (ident[i])
      );
    end else begin : g_off
      assign ident[i] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // mask and enable registers, reserved bits forced low
  // gate bit kept only in enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask   <= MASK_RESET & IMPL;
      enable <= EN_RESET;
    end else begin
      if (wr_mask)
        mask <= bus.reg_wdata & IMPL;
      if (wr_en)
        enable <= bus.reg_wdata & EN_IMPL;
    end
  end

  ////////////////////////////////////////////////////////////
  // read answer one cycle after the strobe, and the irq
  // rdata holds until the next read
  // irq lags an enable write by a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus.reg_rdata  <= 32'h00000000;
      bus.reg_rvalid <= 1'b0;
      bus.cpu_irq    <= 1'b0;
    end else begin
      bus.reg_rvalid <= bus.reg_rd;
      if (bus.reg_rd)
        bus.reg_rdata <= rd_mux;
      bus.cpu_irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////
  // sync toggle waits for every engine to be flushed
  // an early flush waits for idle engines
  // a level, so a read sees the change
  wire flush_pend = flush_wait | flush_sync_done;
  wire sync_fire  = flush_pend & engines_flushed;

  // fence bit held back until its data store is done;
  // the legacy line path gives no ordering, so no wait
  // a second notify while waiting merges
  wire fence_pend = fence_wait | fence_notify;
  wire fence_fire = legacy_line_mode ? fence_notify
                  : fence_pend & fence_store_done;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flush_wait <= 1'b0;
      sync_tgl   <= 1'b0;
      fence_wait <= 1'b0;
      fence_out  <= 1'b0;
    end else begin
      flush_wait <= flush_pend & ~sync_fire;
      if (sync_fire)
        sync_tgl <= ~sync_tgl;
      fence_wait <= fence_pend & ~fence_fire & ~legacy_line_mode;
      fence_out  <= fence_fire;
    end
  end

  ////////////////////////////////////////////////////////////
  // core source vector per variant
  // only one variant reaches the output
  wire msg_hit = bus.msg_valid &
    (bus.msg_addr == CORE_MSG_ADDR);
  // message bits are one-cycle pulses of written ones
  // other targets are ignored here
  wire [31:0] core_v2 = msg_hit ? (bus.msg_data & CORE_MAP_V2)
                      : 32'h00000000;
  // wires: counters 9, 6, fault 7, user 0 and 5; 31:10 zero
  // bits 2 and 4 come from local logic, bit 3 from core_error
  wire [31:0] core_wired = core_wires & CORE_MAP_V1;
  logic [31:0] core_v1;  // first variant assembly
  always_comb begin
    core_v1             = core_wired;
    core_v1[CORE_SYNC]  = sync_tgl;
    core_v1[CORE_ERROR] = core_error;
    core_v1[CORE_FENCE] = fence_out;
  end
  wire [31:0] next_core =
    (VARIANT == 1) ? core_v1 : core_v2;
  // registered: the output comes from a flop

  always_ff @(posedge aclk) begin
    if (!aresetn)
      core_sources <= 32'h00000000;
    else
      core_sources <= next_core;
  end
endmodule // dgia_device
`default_nettype wire

// *** dgia_props.sv ***
`timescale 1ns/1ns
`default_nettype none
// checks the device port between the host end and the device end
module dgia_props #(
  parameter int VARIANT = 2  // variant of the device end
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [19:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        msg_valid,
  input wire logic [19:0] msg_addr,
  input wire logic [31:0] msg_data,
  input wire logic        cpu_irq
);
  import dgia_pkg::*;
  // display bits that exist; the gate bit lives only in enable
  localparam logic [31:0] IMPL = (VARIANT == 2) ? DISP_IMPL_V2
                                                : DISP_IMPL_V1;
  logic [31:0] mask_q;  // shadow of the mask word
  logic [31:0] en_q;    // shadow of the enable word
  wire wr_mask = reg_wr && (reg_addr == DISP_MASK_OFS);
  wire wr_en   = reg_wr && (reg_addr == DISP_EN_OFS);
  wire rd_mask = reg_rd && (reg_addr == DISP_MASK_OFS);
  wire rd_en   = reg_rd && (reg_addr == DISP_EN_OFS);
  wire rd_stat = reg_rd && (reg_addr == DISP_LIVE_OFS
                            || reg_addr == DISP_IDENT_OFS);
  wire master  = en_q[MASTER_BIT];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////
  // shadows follow the writes the device takes at the same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= MASK_RESET;
      en_q   <= EN_RESET;
    end else if (wr_mask) begin
      mask_q <= reg_wdata;
    end else if (wr_en) begin
      en_q <= reg_wdata;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe got no answer");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without a strobe");
  a_mask_back: assert property (
    rd_mask |=> reg_rdata == (mask_q & IMPL))
    else $error("mask read differs from written value");
  a_enable_back: assert property (
    rd_en |=> reg_rdata == (en_q & (IMPL | MASTER_MASK)))
    else $error("enable read differs from written value");
  a_reserved_zero: assert property (
    rd_stat |=> (reg_rdata & ~IMPL) == 32'h00000000)
    else $error("reserved status bit reads one");
  a_master_gate: assert property (!$past(master) |-> !cpu_irq)
    else $error("cpu interrupt with gate bit clear");
  a_msg_target: assert property (
    msg_valid |-> msg_addr == CORE_MSG_ADDR)
    else $error("message sent to wrong target");
  a_msg_single: assert property (msg_valid |=> !msg_valid)
    else $error("message strobe longer than one cycle");
  // main scenarios reached
  c_mask_read: cover property (rd_mask ##1 reg_rvalid);
  c_irq_rise: cover property ($rose(cpu_irq));
  c_message: cover property (msg_valid && msg_data != 32'h00000000);
endmodule // dgia_props
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dgia_pkg::*;
  logic        aclk;
  logic        aresetn = 1'b0;  // synchronous, active low
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0]  wstrb = 4'hF;    // whole words only
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, core_sources, core_sources_v1;
  logic [31:0] display_events = 32'h0, core_wires = 32'h0;
  logic        core_error = 1'b0, flush_sync_done = 1'b0;
  logic        engines_flushed = 1'b0, fence_notify = 1'b0;
  logic        fence_store_done = 1'b0, legacy_line_mode = 1'b0;
  logic        core_irq_result = 1'b0, power_irq_result = 1'b0;
  logic [31:0] seen_msg = 32'h0;  // core bits seen on variant 2
  int          fence_cnt = 0;     // fence pulses on variant 1
  int          bad_count = 0;
  int          checks_done = 0;
  dgia_if dgia_if_inst ();
  dgia_if dgia_if_v1_inst ();
  // variant 1 end hears the same port traffic; its answers are unused
  assign dgia_if_v1_inst.reg_addr  = dgia_if_inst.reg_addr;
  assign dgia_if_v1_inst.reg_wr    = dgia_if_inst.reg_wr;
  assign dgia_if_v1_inst.reg_rd    = dgia_if_inst.reg_rd;
  assign dgia_if_v1_inst.reg_wdata = dgia_if_inst.reg_wdata;
  assign dgia_if_v1_inst.msg_valid = dgia_if_inst.msg_valid;
  assign dgia_if_v1_inst.msg_addr  = dgia_if_inst.msg_addr;
  assign dgia_if_v1_inst.msg_data  = dgia_if_inst.msg_data;
  dgia_host dgia_host_inst (.aclk, .aresetn, .bus(dgia_if_inst),
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready);
  dgia_device #(.VARIANT(2)) dgia_device_inst (.aclk, .aresetn,
    .bus(dgia_if_inst), .display_events, .core_wires, .core_error,
    .flush_sync_done, .engines_flushed, .fence_notify,
    .fence_store_done, .legacy_line_mode, .core_irq_result,
    .power_irq_result, .core_sources);
  dgia_device #(.VARIANT(1)) dgia_device_v1_inst (.aclk, .aresetn,
    .bus(dgia_if_v1_inst), .display_events, .core_wires, .core_error,
    .flush_sync_done, .engines_flushed, .fence_notify,
    .fence_store_done, .legacy_line_mode, .core_irq_result,
    .power_irq_result, .core_sources(core_sources_v1));
  dgia_props #(.VARIANT(2)) dgia_props_inst (.aclk, .aresetn,
    .reg_addr(dgia_if_inst.reg_addr), .reg_wr(dgia_if_inst.reg_wr),
    .reg_rd(dgia_if_inst.reg_rd), .reg_wdata(dgia_if_inst.reg_wdata),
    .reg_rdata(dgia_if_inst.reg_rdata),
    .reg_rvalid(dgia_if_inst.reg_rvalid),
    .msg_valid(dgia_if_inst.msg_valid),
    .msg_addr(dgia_if_inst.msg_addr),
    .msg_data(dgia_if_inst.msg_data), .cpu_irq(dgia_if_inst.cpu_irq));
  //////////////////////////////////////////////////////////////////////////
  // 8 ns clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // core bits last one cycle, so collect them as they pass
  always @(posedge aclk) begin
    if (aresetn) begin
      seen_msg <= seen_msg | core_sources;
    end
    if (aresetn && core_sources_v1[CORE_FENCE] === 1'b1) begin
      fence_cnt <= fence_cnt + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  // a wait that runs out ends the run
  task automatic hung(input string what);
    $display("BAD %s expected answer seen none", what);
    bad_count++;
    conclude();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 100);
    bready <= 1'b0;
    if (!bvalid) hung("write response");
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, bresp});
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 100);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (!rvalid) hung("read response");
  endtask
  task automatic dev_wr(input logic [19:0] ofs, input logic [31:0] d);
    axi_wr(H_ADDR_OFS, {12'h000, ofs});
    axi_wr(H_WDATA_OFS, d);
    axi_wr(H_CTRL_OFS, 32'h00000001);
  endtask
  // device read: start it, poll busy, then fetch the captured word
  task automatic rchk(input string what, input logic [19:0] ofs,
                      input logic [31:0] exp);
    logic [31:0] s;
    logic [1:0]  r;
    int          n;
    axi_wr(H_ADDR_OFS, {12'h000, ofs});
    axi_wr(H_CTRL_OFS, 32'h00000002);
    n = 0;
    do begin
      axi_rd(H_STATUS_OFS, s, r);
      n++;
    end while (s[STAT_BUSY] !== 1'b0 && n < 20);
    if (s[STAT_BUSY] !== 1'b0) hung("device read");
    axi_rd(H_RDATA_OFS, s, r);
    chk(what, exp, s);
  endtask
  // lets an enable change reach the interrupt line first
  task automatic irq_chk(input logic e);
    logic [31:0] s;
    logic [1:0]  r;
    tick(4);
    axi_rd(H_STATUS_OFS, s, r);
    chk("cpu irq", {31'h0, e}, {31'h0, s[STAT_IRQ]});
  endtask
  task automatic ev(input logic [31:0] v);
    @(posedge aclk);
    display_events <= v;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    tick(2);
    rchk("live", DISP_LIVE_OFS, 32'h0);
    rchk("mask", DISP_MASK_OFS, DISP_IMPL_V2);
    rchk("ident", DISP_IDENT_OFS, IDENT_RESET);
    rchk("enable", DISP_EN_OFS, EN_RESET);
    rchk("unmapped", 20'h44030, 32'h0);
    dev_wr(DISP_LIVE_OFS, 32'hFFFFFFFF);
    rchk("live write", DISP_LIVE_OFS, 32'h0);
    dev_wr(DISP_EN_OFS, 32'hFFFFFFFF);
    rchk("enable all", DISP_EN_OFS, DISP_IMPL_V2 | MASTER_MASK);
    dev_wr(DISP_EN_OFS, 32'h0);
    dev_wr(DISP_MASK_OFS, 32'hFFFFFFFC);
    // bit 0 unmasked, bit 2 still masked
    ev(32'h00000005);
    rchk("live held", DISP_LIVE_OFS, 32'h00000005);
    ev(32'h0);
    rchk("ident sticky", DISP_IDENT_OFS, 32'h00000001);
    dev_wr(DISP_EN_OFS, 32'h00000001);
    irq_chk(1'b0);
    dev_wr(DISP_EN_OFS, 32'h80000001);
    irq_chk(1'b1);
    dev_wr(DISP_EN_OFS, MASTER_MASK);
    irq_chk(1'b0);
    ev(32'h00000002);
    ev(32'h0);
    rchk("disabled latch", DISP_IDENT_OFS, 32'h00000003);
    dev_wr(DISP_IDENT_OFS, 32'h00000002);
    rchk("clear one", DISP_IDENT_OFS, 32'h00000001);
    // second occurrence while bit 0 is still set
    ev(32'h00000001);
    ev(32'h0);
    dev_wr(DISP_IDENT_OFS, 32'h00000001);
    rchk("queued", DISP_IDENT_OFS, 32'h00000001);
    dev_wr(DISP_IDENT_OFS, 32'h00000001);
    rchk("drained", DISP_IDENT_OFS, 32'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      core_irq_result  <= (i == 0);
      power_irq_result <= (i == 1);
      irq_chk(1'b1);
    end
    dev_wr(DISP_EN_OFS, 32'h0);
    irq_chk(1'b0);
    axi_wr(H_MSG_OFS, 32'hFFFFFFFF);
    tick(4);
    chk("msg map", CORE_MAP_V2, seen_msg);
    axi_rd(8'h18, d, r);
    chk("axi unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    // variant 1 wires, one cycle through
    @(posedge aclk);
    core_wires <= 32'hFFFFFFFF;
    tick(3);
    chk("wires", 32'h000002E1, core_sources_v1);
    core_error <= 1'b1;
    tick(3);
    chk("error", 32'h000002E9, core_sources_v1);
    for (int i = 0; i < 2; i++) begin
      engines_flushed <= (i == 1);
      flush_sync_done <= 1'b1;
      tick(1);
      flush_sync_done <= 1'b0;
      tick(3);
      chk("sync", 32'h000002E9 | (i << 2), core_sources_v1);
    end
    // fence waits for its store unless the line mode is in use
    fence_notify <= 1'b1;
    tick(1);
    fence_notify <= 1'b0;
    tick(3);
    chk("fence early", 32'd0, fence_cnt);
    fence_store_done <= 1'b1;
    tick(1);
    fence_store_done <= 1'b0;
    tick(3);
    chk("fence stored", 32'd1, fence_cnt);
    legacy_line_mode <= 1'b1;
    fence_notify     <= 1'b1;
    tick(1);
    fence_notify <= 1'b0;
    tick(3);
    chk("fence legacy", 32'd2, fence_cnt);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
